// file: rtl/eadec_consts.vh
// constants of the emulation-map address decoder
`ifndef EADEC_CONSTS_VH
`define EADEC_CONSTS_VH

// apb register byte offsets
`define EADEC_OFS_CTRL      8'h00
`define EADEC_OFS_TOP       8'h04
`define EADEC_OFS_STATUS    8'h08
`define EADEC_OFS_ERR       8'h0C
`define EADEC_OFS_LASTADDR  8'h10

// control register field positions
`define EADEC_CTRL_MSE_EN   0
`define EADEC_CTRL_TEA_EN   1
`define EADEC_CTRL_DISCONT  2
`define EADEC_CTRL_CPU_HOLE 3
`define EADEC_CTRL_PCI_HOLE 4
`define EADEC_CTRL_ROM_LO   5
`define EADEC_CTRL_ROM_HI   6
`define EADEC_CTRL_ROM8     7
`define EADEC_CTRL_W        8

// error register field positions
`define EADEC_ERR_MSE       0
`define EADEC_ERR_TEA       1

// reset values
`define EADEC_CTRL_RST      8'h00
`define EADEC_TOP_RST       8'h3F

// processor address windows
`define EADEC_HOLE_LO       32'h000A_0000
`define EADEC_HOLE_HI       32'h000B_FFFF
`define EADEC_PHOLE_HI      32'h000F_FFFF
`define EADEC_RSVD_LO       32'h4000_0000
`define EADEC_RSVD_HI       32'h7FFF_FFFF
`define EADEC_PMEM_LO       32'h8000_0000
`define EADEC_PMEM_HI       32'hFCFF_FFFF
`define EADEC_ISAM_LO       32'hFD00_0000
`define EADEC_ISAM_HI       32'hFDFF_FFFF
`define EADEC_ISAIO_LO      32'hFE00_0000
`define EADEC_ISAIO_HI      32'hFE7F_FFFF
`define EADEC_IO_LO         32'hFE80_0000
`define EADEC_IO_HI         32'hFEBF_FFFF
`define EADEC_CFGA_LO       32'hFEC0_0000
`define EADEC_CFGA_HI       32'hFEDF_FFFF
`define EADEC_CFGD_LO       32'hFEE0_0000
`define EADEC_CFGD_HI       32'hFEEF_FFFF
`define EADEC_IACK_LO       32'hFEF0_0000
`define EADEC_IACK_HI       32'hFEFF_FFFF
`define EADEC_ROM64_LO      32'hFF00_0000
`define EADEC_ROM64_HI      32'hFF7F_FFFF
`define EADEC_ROMX_LO       32'hFF80_0000
`define EADEC_SYSM_LO       32'h0010_0000

// decode classes
`define EADEC_CL_SYSMEM     4'h0
`define EADEC_CL_PCIMEM     4'h1
`define EADEC_CL_PCIIO      4'h2
`define EADEC_CL_CFGADDR    4'h3
`define EADEC_CL_CFGDATA    4'h4
`define EADEC_CL_INTACK     4'h5
`define EADEC_CL_ROMLOC     4'h6
`define EADEC_CL_ROMPCI     4'h7
`define EADEC_CL_RSVD       4'h8
`define EADEC_CL_TEA        4'h9

`endif

// file: rtl/eadec_cpu_map.v
// processor-side address classification and translation
`timescale 1ns/1ps
`include "eadec_consts.vh"
module eadec_cpu_map (
  addr,
  we,
  io_discont,
  cpu_hole_pci,
  rom_lo_pci,
  rom_hi_pci,
  cls,
  pci_addr
);
  input  wire [31:0] addr;         // processor byte address, bit 0 lsb
  input  wire        we;           // write when high
  input  wire        io_discont;   // discontiguous legacy i/o mode
  input  wire        cpu_hole_pci; // hole goes to pci memory when high
  input  wire        rom_lo_pci;   // lower rom half lives on pci
  input  wire        rom_hi_pci;   // upper rom half lives on pci
  output reg  [3:0]  cls;          // decode class
  output reg  [31:0] pci_addr;     // translated address

  // inclusive window test, used for every window but the open-ended upper rom half
  function in_rng;
    input [31:0] a;
    input [31:0] lo;
    input [31:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  // classify; pass-through address unless a window translates it
  always @* begin
    cls      = `EADEC_CL_SYSMEM;
    pci_addr = addr;
    if (in_rng(addr, `EADEC_HOLE_LO, `EADEC_HOLE_HI)) begin
      cls = cpu_hole_pci ? `EADEC_CL_PCIMEM : `EADEC_CL_SYSMEM;
    end else if (in_rng(addr, `EADEC_RSVD_LO, `EADEC_RSVD_HI)) begin
      cls = `EADEC_CL_RSVD;
    end else if (in_rng(addr, `EADEC_PMEM_LO, `EADEC_PMEM_HI)) begin
      cls = `EADEC_CL_PCIMEM;
    end else if (in_rng(addr, `EADEC_ISAM_LO, `EADEC_ISAM_HI)) begin
      cls      = `EADEC_CL_PCIMEM;
      pci_addr = {8'h00, addr[23:0]};
    end else if (in_rng(addr, `EADEC_ISAIO_LO, `EADEC_ISAIO_HI)) begin
      if (io_discont) begin
        cls      = `EADEC_CL_PCIIO;
        // big-endian a9..a19 are bits 22..12, a27..a31 are bits 4..0
        pci_addr = {16'h0000, addr[22:12], addr[4:0]};
      end else begin
        // only the first 64 kbytes exist in contiguous mode
        cls      = (addr[23:16] == 8'h00) ? `EADEC_CL_PCIIO : `EADEC_CL_RSVD;
        pci_addr = {8'h00, addr[23:0]};
      end
    end else if (in_rng(addr, `EADEC_IO_LO, `EADEC_IO_HI)) begin
      cls      = `EADEC_CL_PCIIO;
      pci_addr = {8'h00, addr[23:0]};
    end else if (in_rng(addr, `EADEC_CFGA_LO, `EADEC_CFGA_HI)) begin
      cls = `EADEC_CL_CFGADDR;
    end else if (in_rng(addr, `EADEC_CFGD_LO, `EADEC_CFGD_HI)) begin
      cls = `EADEC_CL_CFGDATA;
    end else if (in_rng(addr, `EADEC_IACK_LO, `EADEC_IACK_HI)) begin
      cls = we ? `EADEC_CL_TEA : `EADEC_CL_INTACK;
    end else if (in_rng(addr, `EADEC_ROM64_LO, `EADEC_ROM64_HI)) begin
      cls = rom_lo_pci ? `EADEC_CL_ROMPCI : `EADEC_CL_ROMLOC;
    end else if (addr >= `EADEC_ROMX_LO) begin
      // same address on both buses, no translation
      cls = rom_hi_pci ? `EADEC_CL_ROMPCI : `EADEC_CL_ROMLOC;
    end
  end
endmodule // eadec_cpu_map

// file: rtl/eadec_pci_claim.v
// inbound pci cycle claim decision
`timescale 1ns/1ps
`include "eadec_consts.vh"
module eadec_pci_claim (
  addr,
  is_io,
  top_field,
  pci_hole_sys,
  claim
);
  input  wire [31:0] addr;         // pci address
  input  wire        is_io;        // i/o cycle when high
  input  wire [7:0]  top_field;    // system memory top, 1 mbyte units
  input  wire        pci_hole_sys; // hole goes to system memory when high
  output reg         claim;        // forward to system memory

  // i/o cycles never reach memory; top bound only gates the upper area
  always @* begin
    claim = 1'b0;
    if (is_io) begin
      claim = 1'b0;
    end else if (addr < `EADEC_HOLE_LO) begin
      claim = 1'b1;
    end else if (addr <= `EADEC_PHOLE_HI) begin
      claim = pci_hole_sys;
    end else begin
      // bits 31..28 must be zero, 27..20 compared to the top field
      claim = (addr[31:28] == 4'h0) && (addr[27:20] <= top_field);
    end
  end
endmodule // eadec_pci_claim

// file: rtl/eadec_top.v
// emulation-map address decoder with apb control registers
//
// Notes on behaviour
// - reserved 1g-2g: error or all-ones reads
// - isa memory window forwarded, top byte cleared
// - upper i/o window forwarded, top byte cleared
// - contiguous i/o: top byte cleared, rest reserved
// - discontiguous i/o address built from split bits
// - config index range aliases to one port
// - config data range aliases to one port
// - int-ack read launches cycle; write gives error
// - top 16m is rom, upper half width selectable
// - rom may sit locally, on pci, or both
// - compatibility hole steered by two control bits
// - claim pci memory from 1m to top
// - above top, leave pci memory to others
// - top field never affects processor forwarding
// - pci i/o never makes a memory cycle
// - registers little-endian, bit 0 least significant
//
// every answer is registered, one cycle after its strobe;
// pulses stand one cycle, the rest until the next request;
// apb answers in the first access cycle, no wait states;
// inputs are taken as already on clk_sys, no synchronisers
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
`include "eadec_consts.vh"
module eadec_top (
  clk_sys,
  rst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  cpu_req,
  cpu_addr,
  cpu_we,
  cpu_done,
  cpu_class,
  cpu_pci_addr,
  cpu_rd_ones,
  cpu_wr_drop,
  cpu_rom8,
  mem_sel_err,
  transfer_error_ack,
  pci_req,
  pci_addr,
  pci_is_io,
  pci_done,
  pci_claim,
  pci_mem_addr
);
  input  wire        clk_sys;            // 20 mhz system clock
  input  wire        rst;                // synchronous, active high
  input  wire        psel;               // apb select
  input  wire        penable;            // apb access phase
  input  wire        pwrite;             // apb write
  input  wire [7:0]  paddr;              // apb byte address
  input  wire [31:0] pwdata;             // apb write data
  output reg  [31:0] prdata;             // apb read data
  output reg         pready;             // apb ready
  output reg         pslverr;            // apb error on unmapped address
  input  wire        cpu_req;            // processor request strobe
  input  wire [31:0] cpu_addr;           // processor address
  input  wire        cpu_we;             // processor write
  output reg         cpu_done;           // decode result valid, one cycle
  output reg  [3:0]  cpu_class;          // decode class
  output reg  [31:0] cpu_pci_addr;       // translated address
  output reg         cpu_rd_ones;        // answer read with all ones
  output reg         cpu_wr_drop;        // discard this write
  output reg         cpu_rom8;           // rom access is 8-bit wide
  output reg         mem_sel_err;        // memory select error pulse
  output reg         transfer_error_ack; // transfer error pulse
  input  wire        pci_req;            // inbound pci request strobe
  input  wire [31:0] pci_addr;           // inbound pci address
  input  wire        pci_is_io;          // inbound cycle is i/o
  output reg         pci_done;           // claim result valid, one cycle
  output reg         pci_claim;          // claim for system memory
  output reg  [31:0] pci_mem_addr;       // system memory address

  ////////////////////////////////////////////////////////////////////
  // control state
  // all that software can program lives here
  reg [`EADEC_CTRL_W-1:0] ctrl_r;     // control bits
  reg [7:0]               top_r;      // system_memory_top_field
  reg [1:0]               err_r;      // sticky error flags
  reg [3:0]               last_cls_r; // last processor class
  reg                     last_clm_r; // last pci claim answer

  wire mse_en       = ctrl_r[`EADEC_CTRL_MSE_EN];
  wire tea_en       = ctrl_r[`EADEC_CTRL_TEA_EN];
  wire io_discont   = ctrl_r[`EADEC_CTRL_DISCONT];
  wire cpu_hole_pci = ctrl_r[`EADEC_CTRL_CPU_HOLE]; // cpu_side_legacy_hole_steer
  wire pci_hole_sys = ctrl_r[`EADEC_CTRL_PCI_HOLE];
  wire rom_lo_pci   = ctrl_r[`EADEC_CTRL_ROM_LO];
  wire rom_hi_pci   = ctrl_r[`EADEC_CTRL_ROM_HI];
  wire rom8         = ctrl_r[`EADEC_CTRL_ROM8];

  ////////////////////////////////////////////////////////////////////
  // decoders; the processor map is given no top field at all
  // both are pure logic; their answers are registered below
  // so every output leaves the block from a flip-flop
  wire [3:0]  map_cls;  // processor class
  wire [31:0] map_addr; // processor translated address
  wire        map_clm;  // inbound claim

  eadec_cpu_map u_cpu_map (
    .addr         (cpu_addr),
    .we           (cpu_we),
    .io_discont   (io_discont),
    .cpu_hole_pci (cpu_hole_pci),
    .rom_lo_pci   (rom_lo_pci),
    .rom_hi_pci   (rom_hi_pci),
    .cls          (map_cls),
    .pci_addr     (map_addr)
  );

  eadec_pci_claim u_pci_claim (
    .addr         (pci_addr),
    .is_io        (pci_is_io),
    .top_field    (top_r),
    .pci_hole_sys (pci_hole_sys),
    .claim        (map_clm)
  );

  ////////////////////////////////////////////////////////////////////
  // processor side result registers
  // reserved and int-ack hits are decided once, shared by the
  // pulses, the sticky flags and the drop/all-ones qualifiers
  wire cpu_rsvd = (map_cls == `EADEC_CL_RSVD);
  wire cpu_tea  = (map_cls == `EADEC_CL_TEA);
  wire rom_hit  = (map_cls == `EADEC_CL_ROMLOC) || (map_cls == `EADEC_CL_ROMPCI);
  // only the upper rom half may be narrow; lower half stays 64-bit
  // taken from the raw address, since both halves share a class
  wire rom_up   = (cpu_addr >= `EADEC_ROMX_LO);
  wire set_mse  = cpu_req && cpu_rsvd && mse_en;
  wire set_tea  = cpu_req && cpu_tea && tea_en;

  // class and address hold until the next strobe, so a slow
  // consumer may read them late; the pulses are one-shot
  // a request every cycle is fine: nothing here is multi-cycle
  // one result per request, presented the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rst) begin
      cpu_done           <= 1'b0;
      cpu_class          <= `EADEC_CL_SYSMEM;
      cpu_pci_addr       <= 32'h0000_0000;
      cpu_rd_ones        <= 1'b0;
      cpu_wr_drop        <= 1'b0;
      cpu_rom8           <= 1'b0;
      mem_sel_err        <= 1'b0;
      transfer_error_ack <= 1'b0;
      last_cls_r         <= `EADEC_CL_SYSMEM;
    end else begin
      cpu_done           <= cpu_req;
      mem_sel_err        <= set_mse;
      transfer_error_ack <= set_tea;
      if (cpu_req) begin
        cpu_class    <= map_cls;
        cpu_pci_addr <= map_addr;
        // with the error off, reads float high and writes vanish
        cpu_rd_ones  <= cpu_rsvd && !mse_en && !cpu_we;
        // an int-ack write never updates anything, error or not
        cpu_wr_drop  <= cpu_we && (cpu_rsvd || cpu_tea);
        cpu_rom8     <= rom_hit && rom_up && rom8;
        last_cls_r   <= map_cls;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // inbound pci result registers
  // claim rules live in the claim module; this stage registers
  // the address is zeroed when not claimed, so a stale one
  // can never pass for a live system memory address
  always @(posedge clk_sys) begin
    if (rst) begin
      pci_done     <= 1'b0;
      pci_claim    <= 1'b0;
      pci_mem_addr <= 32'h0000_0000;
      last_clm_r   <= 1'b0;
    end else begin
      pci_done <= pci_req;
      if (pci_req) begin
        pci_claim    <= map_clm;
        // claimed addresses map one to one onto system memory
        pci_mem_addr <= map_clm ? pci_addr : 32'h0000_0000;
        last_clm_r   <= map_clm;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb slave: answer prepared in setup, ready in the first access cycle
  // register map, one aligned word each:
  //   0x00 control: b0 select error on, b1 transfer error on,
  //        b2 discontiguous i/o, b3 cpu hole to pci,
  //        b4 pci hole to memory, b5/b6 lower/upper rom on pci,
  //        b7 upper rom 8-bit
  //   0x04 system_memory_top_field, 1 mbyte units
  //   0x08 status, read only: last class and last claim
  //   0x0c error flags, write one to clear
  //   0x10 last translated cpu address, read only
  // unmapped offsets answer with pslverr
  function [2:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `EADEC_OFS_CTRL:     reg_sel = 3'd1;
        `EADEC_OFS_TOP:      reg_sel = 3'd2;
        `EADEC_OFS_STATUS:   reg_sel = 3'd3;
        `EADEC_OFS_ERR:      reg_sel = 3'd4;
        `EADEC_OFS_LASTADDR: reg_sel = 3'd5;
        default:             reg_sel = 3'd0;
      endcase
    end
  endfunction

  wire       apb_setup = psel && !penable;
  wire       apb_done  = psel && penable && pready;
  wire [2:0] sel       = reg_sel(paddr);
  wire       wr_ok     = apb_done && pwrite && !pslverr;

  // read mux; bit 0 of each register is data bit 0
  // status and last address reflect the last request only
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (sel)
      3'd1:    rd_nxt = {24'h00_0000, ctrl_r};
      3'd2:    rd_nxt = {24'h00_0000, top_r};
      3'd3:    rd_nxt = {27'h000_0000, last_clm_r, last_cls_r};
      3'd4:    rd_nxt = {30'h0000_0000, err_r};
      3'd5:    rd_nxt = cpu_pci_addr;
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  // bus handshake; reserved bits read zero and ignore writes
  // pready rises only after a setup cycle, so it never spans
  // two accesses; read data are zero outside that cycle
  always @(posedge clk_sys) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (apb_setup) begin
      pready  <= 1'b1;
      pslverr <= (sel == 3'd0);
      prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // writable registers
  // only a completed, error-free access writes; writes to
  // unmapped or read-only offsets vanish without side effects
  // control has no reserved bits in its byte, so all of it
  // is taken; data bits above the byte are ignored
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_r <= `EADEC_CTRL_RST;
      top_r  <= `EADEC_TOP_RST;
    end else if (wr_ok) begin
      if (sel == 3'd1) begin
        ctrl_r <= pwdata[`EADEC_CTRL_W-1:0];
      end
      if (sel == 3'd2) begin
        top_r <= pwdata[7:0];
      end
    end
  end

  // sticky errors: write one clears, a new event in the same cycle wins
  // each flag clears alone; losing the clear means no event
  // is ever missed, at the cost of one more clear by software
  always @(posedge clk_sys) begin
    if (rst) begin
      err_r <= 2'b00;
    end else begin
      if (set_mse) begin
        err_r[`EADEC_ERR_MSE] <= 1'b1;
      end else if (wr_ok && (sel == 3'd4) && pwdata[`EADEC_ERR_MSE]) begin
        err_r[`EADEC_ERR_MSE] <= 1'b0;
      end
      if (set_tea) begin
        err_r[`EADEC_ERR_TEA] <= 1'b1;
      end else if (wr_ok && (sel == 3'd4) && pwdata[`EADEC_ERR_TEA]) begin
        err_r[`EADEC_ERR_TEA] <= 1'b0;
      end
    end
  end
endmodule // eadec_top

// file: bench/eadec_chk_assertions.sv
// port-level assertion checker for the emulation-map decoder
`timescale 1ns/1ps
module eadec_chk (
  input wire        clk_sys,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        cpu_req,
  input wire [31:0] cpu_addr,
  input wire        cpu_we,
  input wire        cpu_done,
  input wire [3:0]  cpu_class,
  input wire [31:0] cpu_pci_addr,
  input wire        cpu_rd_ones,
  input wire        mem_sel_err,
  input wire        transfer_error_ack,
  input wire        pci_req,
  input wire [31:0] pci_addr,
  input wire        pci_is_io,
  input wire        pci_done,
  input wire        pci_claim,
  input wire [31:0] pci_mem_addr
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // processor side: class and translation tied to the request
  a_done_next: assert property (cpu_req |=> cpu_done)
    else $error("decode result missing");
  a_rsvd_class: assert property (cpu_req && cpu_addr[31:30] == 2'b01 |=> cpu_class == 4'h8)
    else $error("reserved range not flagged");
  a_mse_cause: assert property (mem_sel_err |-> cpu_done && cpu_class == 4'h8 && !cpu_rd_ones)
    else $error("select error without reserved access");
  a_isa_xlat: assert property (cpu_req && cpu_addr[31:24] == 8'hFD |=>
    cpu_class == 4'h1 && cpu_pci_addr == {8'h00, $past(cpu_addr[23:0])})
    else $error("isa memory translation wrong");
  a_upper_io: assert property (cpu_req && cpu_addr[31:22] == 10'h3FA |=>
    cpu_class == 4'h2 && cpu_pci_addr == {8'h00, $past(cpu_addr[23:0])})
    else $error("upper io translation wrong");
  a_cfg_index: assert property (cpu_req && cpu_addr[31:21] == 11'h7F6 |=> cpu_class == 4'h3)
    else $error("config index alias wrong");
  a_cfg_data: assert property (cpu_req && cpu_addr[31:20] == 12'hFEE |=> cpu_class == 4'h4)
    else $error("config data alias wrong");
  a_iack_read: assert property (cpu_req && cpu_addr[31:20] == 12'hFEF && !cpu_we |=>
    cpu_class == 4'h5 && !transfer_error_ack)
    else $error("int-ack read wrong");
  a_tea_cause: assert property (transfer_error_ack |-> cpu_done && cpu_class == 4'h9 && $past(cpu_we))
    else $error("transfer error without int-ack write");

  ////////////////////////////////////////////////////////////////////////////
  // inbound pci claims, then the apb ready pulse
  a_io_noclaim: assert property (pci_req && pci_is_io |=> pci_done && !pci_claim)
    else $error("io cycle claimed");
  a_high_noclaim: assert property (pci_req && pci_addr[31:28] != 4'h0 |=> !pci_claim)
    else $error("claim above 256m");
  a_apb_one: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("apb ready not one cycle");
endmodule // eadec_chk

bind eadec_top eadec_chk u_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
  .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_we(cpu_we), .cpu_done(cpu_done),
  .cpu_class(cpu_class), .cpu_pci_addr(cpu_pci_addr), .cpu_rd_ones(cpu_rd_ones),
  .mem_sel_err(mem_sel_err), .transfer_error_ack(transfer_error_ack), .pci_req(pci_req),
  .pci_addr(pci_addr), .pci_is_io(pci_is_io), .pci_done(pci_done), .pci_claim(pci_claim),
  .pci_mem_addr(pci_mem_addr));

// file: bench/eadec_far_model.sv
// processor master and pci agent model driving the request strobes
`timescale 1ns/1ps
module eadec_far_model (
  input wire         clk_sys,
  output logic        cpu_req,
  output logic [31:0] cpu_addr,
  output logic        cpu_we,
  output logic        pci_req,
  output logic [31:0] pci_addr,
  output logic        pci_is_io
);
  // idle values at time zero
  initial begin
    cpu_req = 1'b0; cpu_addr = 32'h0; cpu_we = 1'b0;
    pci_req = 1'b0; pci_addr = 32'h0; pci_is_io = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one-cycle strobe; released lines show the inverse so stale values never match
  task cpu_cycle(input logic [31:0] a, input logic w);
    @(posedge clk_sys); cpu_req <= 1'b1; cpu_addr <= a; cpu_we <= w;
    @(posedge clk_sys); cpu_req <= 1'b0; cpu_addr <= ~a; cpu_we <= ~w;
    #1;
  endtask
  task pci_cycle(input logic [31:0] a, input logic io);
    @(posedge clk_sys); pci_req <= 1'b1; pci_addr <= a; pci_is_io <= io;
    @(posedge clk_sys); pci_req <= 1'b0; pci_addr <= ~a; pci_is_io <= ~io;
    #1;
  endtask
endmodule // eadec_far_model

// file: bench/eadec_top_tb.sv
// self-checking bench for the emulation-map decoder
`timescale 1ns/1ps
`include "eadec_consts.vh"
module eadec_top_tb;
  logic        clk_sys = 1'b0; // 20 mhz
  logic        rst = 1'b1;     // held for two edges
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rdv;            // last apb read data
  logic        err;            // last apb error flag
  int          fails = 0, tests_run = 0, cyc = 0;
  wire [31:0] prdata, cpu_addr, cpu_pci_addr, pci_addr, pci_mem_addr;
  wire [3:0]  cpu_class;
  wire pready, pslverr, cpu_req, cpu_we, cpu_done, cpu_rd_ones, cpu_wr_drop, cpu_rom8;
  wire mem_sel_err, transfer_error_ack, pci_req, pci_is_io, pci_done, pci_claim;

  always #25 clk_sys = ~clk_sys;

  eadec_far_model far (.clk_sys(clk_sys), .cpu_req(cpu_req), .cpu_addr(cpu_addr),
    .cpu_we(cpu_we), .pci_req(pci_req), .pci_addr(pci_addr), .pci_is_io(pci_is_io));
  eadec_top DUT (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_we(cpu_we),
    .cpu_done(cpu_done), .cpu_class(cpu_class), .cpu_pci_addr(cpu_pci_addr),
    .cpu_rd_ones(cpu_rd_ones), .cpu_wr_drop(cpu_wr_drop), .cpu_rom8(cpu_rom8),
    .mem_sel_err(mem_sel_err), .transfer_error_ack(transfer_error_ack), .pci_req(pci_req),
    .pci_addr(pci_addr), .pci_is_io(pci_is_io), .pci_done(pci_done), .pci_claim(pci_claim),
    .pci_mem_addr(pci_mem_addr));

  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("Checks run %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error at %0d ns: got %h expected %h", $time, g, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // apb master: request stands until the rising edge that finds pready high;
  // data are taken and the bus released at that edge; only the hang guard ends a wait
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys); psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys); penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask
  // read-modify-write so the other control bits keep their value
  task setc(input int b, input logic v);
    apb(1'b0, `EADEC_OFS_CTRL, 32'h0);
    rdv[b] = v;
    apb(1'b1, `EADEC_OFS_CTRL, rdv);
  endtask
  task cpu(input logic [31:0] a, input logic w, input logic [3:0] c, input logic [31:0] pa);
    far.cpu_cycle(a, w);
    chk(cpu_done, 1'b1);
    chk(cpu_class, c);
    chk(cpu_pci_addr, pa);
  endtask
  task cpua(input logic [31:0] a, input logic w, input logic [3:0] c);
    cpu(a, w, c, a);
  endtask
  task pci(input logic [31:0] a, input logic io, input logic cl, input logic [31:0] ma);
    far.pci_cycle(a, io);
    chk(pci_done, 1'b1);
    chk(pci_claim, cl);
    chk(pci_mem_addr, ma);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(`EADEC_OFS_CTRL, 32'h0);
    rd(`EADEC_OFS_TOP, 32'h3F);
    rd(`EADEC_OFS_ERR, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1);
    chk(rdv, 32'h0);
    apb(1'b1, `EADEC_OFS_TOP, 32'hFFFF_FF05);
    rd(`EADEC_OFS_TOP, 32'h5);
    apb(1'b1, `EADEC_OFS_TOP, 32'h3F);
    // reserved range, error off then on
    cpua(32'h4000_0000, 1'b0, 4'h8);
    chk({cpu_rd_ones, mem_sel_err}, 2'b10);
    cpua(32'h7FFF_FFFC, 1'b1, 4'h8);
    chk(cpu_wr_drop, 1'b1);
    setc(`EADEC_CTRL_MSE_EN, 1'b1);
    cpua(32'h5000_0000, 1'b0, 4'h8);
    chk({cpu_rd_ones, mem_sel_err}, 2'b01);
    rd(`EADEC_OFS_ERR, 32'h1);
    apb(1'b1, `EADEC_OFS_ERR, 32'h1);
    rd(`EADEC_OFS_ERR, 32'h0);
    // io windows in both modes
    cpu(32'hFEBF_FFFC, 1'b1, 4'h2, 32'h00BF_FFFC);
    cpu(32'hFE00_1234, 1'b0, 4'h2, 32'h0000_1234);
    cpu(32'hFE01_0000, 1'b0, 4'h8, 32'h0001_0000);
    setc(`EADEC_CTRL_DISCONT, 1'b1);
    cpu(32'hFE7A_B5C3, 1'b0, 4'h2, {16'h0, 11'h7AB, 5'h03});
    setc(`EADEC_CTRL_DISCONT, 1'b0);
    // config ports and interrupt acknowledge
    cpua(32'hFED0_0008, 1'b1, 4'h3);
    cpua(32'hFEE1_2340, 1'b0, 4'h4);
    cpua(32'hFEF0_0000, 1'b0, 4'h5);
    setc(`EADEC_CTRL_TEA_EN, 1'b1);
    cpua(32'hFEF0_0010, 1'b1, 4'h9);
    chk({transfer_error_ack, cpu_wr_drop}, 2'b11);
    // rom halves, local and on pci, narrow upper half
    cpua(32'hFF00_0000, 1'b0, 4'h6);
    setc(`EADEC_CTRL_ROM_LO, 1'b1);
    cpua(32'hFF7F_FFF8, 1'b0, 4'h7);
    setc(`EADEC_CTRL_ROM8, 1'b1);
    cpua(32'hFF80_0000, 1'b0, 4'h6);
    chk(cpu_rom8, 1'b1);
    setc(`EADEC_CTRL_ROM_HI, 1'b1);
    cpua(32'hFFFF_FFF0, 1'b0, 4'h7);
    // compatibility hole from both sides
    cpua(32'h000A_0000, 1'b0, 4'h0);
    setc(`EADEC_CTRL_CPU_HOLE, 1'b1);
    cpua(32'h000B_FFF0, 1'b1, 4'h1);
    pci(32'h000B_0000, 1'b0, 1'b0, 32'h0);
    setc(`EADEC_CTRL_PCI_HOLE, 1'b1);
    pci(32'h000F_FFF0, 1'b0, 1'b1, 32'h000F_FFF0);
    // top-of-memory boundary
    pci(32'h0010_0000, 1'b0, 1'b1, 32'h0010_0000);
    pci(32'h03FF_FFFC, 1'b0, 1'b1, 32'h03FF_FFFC);
    pci(32'h0400_0000, 1'b0, 1'b0, 32'h0);
    pci(32'h1010_0000, 1'b0, 1'b0, 32'h0);
    apb(1'b1, `EADEC_OFS_TOP, 32'h10);
    pci(32'h010F_FFFC, 1'b0, 1'b1, 32'h010F_FFFC);
    rd(`EADEC_OFS_STATUS, 32'h11);
    pci(32'h0110_0000, 1'b0, 1'b0, 32'h0);
    cpu(32'hFD12_3456, 1'b0, 4'h1, 32'h0012_3456);
    rd(`EADEC_OFS_LASTADDR, 32'h0012_3456);
    pci(32'h0020_0000, 1'b1, 1'b0, 32'h0);
    close_out;
  end
endmodule // eadec_top_tb
